/* src/sleep_reset_watchdog_control.sv */
// Sleep mode sequencing, clock gating, reset combining and watchdog for the system core.
// Assumes synchronous level inputs, a 1 kHz tick pulse already in this clock domain and a
// zero-wait AHB-Lite slave position with this block as the only slave.
`timescale 1ns/1ps
module sleep_reset_watchdog_control #(
  parameter logic [15:0] BOOT_START = 16'h8000
) (
  input  wire logic                                              i_mclk,
  input  wire logic                                              i_sys_rst,
  input  wire logic                                              i_hsel,
  input  wire logic [31:0]                                       i_haddr,
  input  wire logic [1:0]                                        i_htrans,
  input  wire logic                                              i_hwrite,
  input  wire logic [2:0]                                        i_hsize,
  input  wire logic [31:0]                                       i_hwdata,
  input  wire logic                                              i_hready,
  output logic                                                   o_hreadyout,
  output logic                                                   o_hresp,
  output logic [31:0]                                            o_hrdata,
  input  wire logic                                              i_por_low,
  input  wire logic                                              i_ext_rst_n,
  input  wire logic                                              i_bod_low,
  input  wire logic                                              i_bod_enable,
  input  wire logic                                              i_jtag_rst_bit,
  input  wire logic                                              i_program_debug_link_rst,
  input  wire logic                                              i_boot_reloc,
  input  wire logic                                              i_wdt_always_on,
  input  wire logic                                              i_wdt_tick,
  input  wire logic                                              i_watchdog_restart_instruction,
  input  wire logic                                              i_sleep_exec,
  input  wire logic                                              i_irq_enabled_any,
  input  wire logic                                              i_irq_twi_match,
  input  wire logic                                              i_irq_port_async,
  input  wire logic                                              i_irq_rtc,
  input  wire logic                                              i_rtc_enabled,
  output sleep_reset_watchdog_control_pkg::clk_en_s              o_clk_en,
  output logic [sleep_reset_watchdog_control_pkg::PR_WIDTH-1:0]  o_per_clk_en,
  output logic                                                   o_sleeping,
  output logic                                                   o_sys_reset,
  output logic                                                   o_io_tristate,
  output logic [15:0]                                            o_reset_vector
);

  sleep_reset_watchdog_control_pkg::ctrl_state_s st;
  sleep_reset_watchdog_control_pkg::ctrl_state_s next_st;
  logic [sleep_reset_watchdog_control_pkg::RST_SYNC_STAGES-1:0] rst_chain;
  logic                                                          rst_async;
  logic                                                          rst_sync;
  logic                                                          ctl_rst;
  logic                                                          addr_phase;
  logic                                                          wr_now;
  logic                                                          unlocked;
  logic                                                          mode_ok;
  logic                                                          wake;
  logic                                                          wdt_restart_bad;
  logic                                                          wdt_expired;
  logic [13:0]                                                   wdt_limit;
  logic [13:0]                                                   wdt_min;
  logic [31:0]                                                   rd_value;
  logic [sleep_reset_watchdog_control_pkg::CAUSE_WIDTH-1:0]      cause_now;
  sleep_reset_watchdog_control_pkg::clk_en_s                     clk_now;

  // Period code n selects 8 ms times two to the n, so codes 0 to 10 span 8 ms to 8 s.
  function automatic logic [13:0] wdt_ticks(input logic [3:0] code);
    logic [3:0] c;
    c = (code > sleep_reset_watchdog_control_pkg::WDT_PER_MAX) ?
        sleep_reset_watchdog_control_pkg::WDT_PER_MAX : code;
    return sleep_reset_watchdog_control_pkg::WDT_BASE_TICKS << c;
  endfunction

  function automatic logic mode_valid(input logic [2:0] m);
    return (m == sleep_reset_watchdog_control_pkg::MODE_IDLE)  ||
           (m == sleep_reset_watchdog_control_pkg::MODE_PDOWN) ||
           (m == sleep_reset_watchdog_control_pkg::MODE_PSAVE) ||
           (m == sleep_reset_watchdog_control_pkg::MODE_STDBY) ||
           (m == sleep_reset_watchdog_control_pkg::MODE_ESTDBY);
  endfunction

  // Every source is combined without a clock so the core resets with all oscillators stopped.
  assign rst_async = i_sys_rst | i_por_low | ~i_ext_rst_n | (i_bod_enable & i_bod_low) |
                     i_jtag_rst_bit | i_program_debug_link_rst | st.wdt_fire |
                     st.sw_fire;

  // Asserts at once, releases only after the chain has seen clean clock edges.
  always_ff @(posedge i_mclk or posedge rst_async) begin
    if (rst_async) begin
      rst_chain <= '1;
    end else begin
      rst_chain <= {rst_chain[sleep_reset_watchdog_control_pkg::RST_SYNC_STAGES-2:0], 1'b0};
    end
  end
  assign rst_sync = rst_chain[sleep_reset_watchdog_control_pkg::RST_SYNC_STAGES-1];

  assign o_sys_reset   = rst_async | rst_sync;
  assign o_io_tristate = rst_async | rst_sync;
  assign ctl_rst       = i_sys_rst | rst_sync;

  assign cause_now[sleep_reset_watchdog_control_pkg::CAUSE_POR]   = i_por_low;
  assign cause_now[sleep_reset_watchdog_control_pkg::CAUSE_EXT]   = ~i_ext_rst_n;
  assign cause_now[sleep_reset_watchdog_control_pkg::CAUSE_BOD]   = i_bod_enable & i_bod_low;
  assign cause_now[sleep_reset_watchdog_control_pkg::CAUSE_WDT]   = st.wdt_fire;
  assign cause_now[sleep_reset_watchdog_control_pkg::CAUSE_JTAG]  = i_jtag_rst_bit;
  assign cause_now[sleep_reset_watchdog_control_pkg::CAUSE_DEBUG] = i_program_debug_link_rst;
  assign cause_now[sleep_reset_watchdog_control_pkg::CAUSE_SW]    = st.sw_fire;

  assign addr_phase = i_hsel & i_htrans[1] & i_hready;
  assign wr_now     = st.dp_write;
  assign unlocked   = st.unlock_cnt != 3'h0;
  assign mode_ok    = mode_valid(st.sleep_mode);

  assign wdt_limit       = wdt_ticks(st.wdt_per);
  assign wdt_min         = wdt_ticks(st.wdt_wper);
  assign wdt_expired     = st.wdt_en & i_wdt_tick & (st.wdt_cnt + 14'h1 >= wdt_limit);
  assign wdt_restart_bad = st.wdt_en & st.wdt_win & i_watchdog_restart_instruction &
                           (st.wdt_cnt < wdt_min);

  always_comb begin
    clk_now = '{cpu: 1'b1, nvm: 1'b1, per: 1'b1, rtc: 1'b1, sys_src: 1'b1};
    wake    = 1'b0;
    if (st.pstate == sleep_reset_watchdog_control_pkg::PS_SLEEP) begin
      clk_now = '0;
      case (st.sleep_mode)
        sleep_reset_watchdog_control_pkg::MODE_IDLE: begin
          clk_now.per     = 1'b1;
          clk_now.rtc     = 1'b1;
          clk_now.sys_src = 1'b1;
          wake            = i_irq_enabled_any;
        end
        sleep_reset_watchdog_control_pkg::MODE_PDOWN: begin
          wake = i_irq_twi_match | i_irq_port_async;
        end
        sleep_reset_watchdog_control_pkg::MODE_PSAVE: begin
          clk_now.rtc = i_rtc_enabled;
          wake        = i_irq_twi_match | i_irq_port_async | (i_rtc_enabled & i_irq_rtc);
        end
        sleep_reset_watchdog_control_pkg::MODE_STDBY: begin
          clk_now.sys_src = 1'b1;
          wake            = i_irq_twi_match | i_irq_port_async;
        end
        sleep_reset_watchdog_control_pkg::MODE_ESTDBY: begin
          clk_now.sys_src = 1'b1;
          clk_now.rtc     = i_rtc_enabled;
          wake            = i_irq_twi_match | i_irq_port_async | (i_rtc_enabled & i_irq_rtc);
        end
        default: begin
          wake = 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_value = 32'h0;
    case (i_haddr[7:0])
      sleep_reset_watchdog_control_pkg::OFS_SLEEP_CTRL: begin
        rd_value[sleep_reset_watchdog_control_pkg::SLEEP_EN_BIT] = st.sleep_en;
        rd_value[sleep_reset_watchdog_control_pkg::SLEEP_MODE_LO +: 3] = st.sleep_mode;
      end
      sleep_reset_watchdog_control_pkg::OFS_POWER_RED: begin
        rd_value[sleep_reset_watchdog_control_pkg::PR_WIDTH-1:0] = st.power_red;
      end
      sleep_reset_watchdog_control_pkg::OFS_RST_CAUSE: begin
        rd_value[sleep_reset_watchdog_control_pkg::CAUSE_WIDTH-1:0] = st.cause;
      end
      sleep_reset_watchdog_control_pkg::OFS_WDT_CTRL: begin
        rd_value[sleep_reset_watchdog_control_pkg::WDT_EN_BIT]    = st.wdt_en;
        rd_value[sleep_reset_watchdog_control_pkg::WDT_WIN_BIT]   = st.wdt_win;
        rd_value[sleep_reset_watchdog_control_pkg::WDT_PER_LO +: 4] = st.wdt_per;
      end
      sleep_reset_watchdog_control_pkg::OFS_WDT_WIN: begin
        rd_value[3:0] = st.wdt_wper;
      end
      sleep_reset_watchdog_control_pkg::OFS_STATUS: begin
        rd_value[0]     = st.pstate == sleep_reset_watchdog_control_pkg::PS_SLEEP;
        rd_value[1]     = unlocked;
        rd_value[29:16] = st.wdt_cnt;
      end
      default: begin
        rd_value = 32'h0;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    // The write of the previous address phase lands now; reads are sampled in the address phase.
    next_st.dp_write = addr_phase & i_hwrite;
    next_st.dp_addr  = i_haddr[7:0];
    if (addr_phase & ~i_hwrite) begin
      next_st.hrdata = rd_value;
    end

    if (unlocked) begin
      next_st.unlock_cnt = st.unlock_cnt - 3'h1;
    end

    if (wr_now) begin
      case (st.dp_addr)
        sleep_reset_watchdog_control_pkg::OFS_SLEEP_CTRL: begin
          next_st.sleep_en   = i_hwdata[sleep_reset_watchdog_control_pkg::SLEEP_EN_BIT];
          next_st.sleep_mode = i_hwdata[sleep_reset_watchdog_control_pkg::SLEEP_MODE_LO +: 3];
        end
        sleep_reset_watchdog_control_pkg::OFS_POWER_RED: begin
          next_st.power_red = i_hwdata[sleep_reset_watchdog_control_pkg::PR_WIDTH-1:0];
        end
        sleep_reset_watchdog_control_pkg::OFS_PROT_KEY: begin
          if (i_hwdata[7:0] == sleep_reset_watchdog_control_pkg::PROT_KEY_VALUE) begin
            next_st.unlock_cnt = sleep_reset_watchdog_control_pkg::PROT_WINDOW_CYC;
          end
        end
        sleep_reset_watchdog_control_pkg::OFS_SW_RST: begin
          if (unlocked) begin
            next_st.unlock_cnt = 3'h0;
            next_st.sw_fire    = i_hwdata[sleep_reset_watchdog_control_pkg::SW_RST_BIT];
          end
        end
        sleep_reset_watchdog_control_pkg::OFS_WDT_CTRL: begin
          if (unlocked) begin
            next_st.unlock_cnt = 3'h0;
            next_st.wdt_en  = i_hwdata[sleep_reset_watchdog_control_pkg::WDT_EN_BIT];
            next_st.wdt_win = i_hwdata[sleep_reset_watchdog_control_pkg::WDT_WIN_BIT];
            next_st.wdt_per = i_hwdata[sleep_reset_watchdog_control_pkg::WDT_PER_LO +: 4];
            next_st.wdt_cnt = 14'h0;
          end
        end
        sleep_reset_watchdog_control_pkg::OFS_WDT_WIN: begin
          if (unlocked) begin
            next_st.unlock_cnt = 3'h0;
            next_st.wdt_wper   = i_hwdata[3:0];
          end
        end
        default: begin
          next_st.unlock_cnt = next_st.unlock_cnt;
        end
      endcase
    end

    if (i_wdt_always_on) begin
      next_st.wdt_en = 1'b1;
    end

    // Watchdog count, restart and expiry; expiry raises a request held until reset takes it.
    if (~st.wdt_en) begin
      next_st.wdt_cnt = 14'h0;
    end else if (i_watchdog_restart_instruction) begin
      next_st.wdt_cnt = 14'h0;
    end else if (i_wdt_tick) begin
      next_st.wdt_cnt = st.wdt_cnt + 14'h1;
    end
    if (wdt_expired | wdt_restart_bad) begin
      next_st.wdt_fire = 1'b1;
    end

    // Write-one-to-clear on the cause flags; a source active in the same cycle wins.
    if (wr_now && st.dp_addr == sleep_reset_watchdog_control_pkg::OFS_RST_CAUSE) begin
      next_st.cause = st.cause & ~i_hwdata[sleep_reset_watchdog_control_pkg::CAUSE_WIDTH-1:0];
    end
    if (rst_sync) begin
      next_st.cause = next_st.cause | cause_now;
    end

    case (st.pstate)
      sleep_reset_watchdog_control_pkg::PS_ACTIVE: begin
        if (i_sleep_exec & st.sleep_en & mode_ok) begin
          next_st.pstate = sleep_reset_watchdog_control_pkg::PS_SLEEP;
        end
      end
      sleep_reset_watchdog_control_pkg::PS_SLEEP: begin
        if (wake) begin
          next_st.pstate = sleep_reset_watchdog_control_pkg::PS_ACTIVE;
        end
      end
      default: begin
        next_st.pstate = sleep_reset_watchdog_control_pkg::PS_ACTIVE;
      end
    endcase

    // Every control register returns to its initial value; the cause log survives except under i_sys_rst, which clears it.
    if (ctl_rst) begin
      next_st            = '0;
      next_st.cause      = i_sys_rst ? '0 : (st.cause | cause_now);
      next_st.wdt_en     = i_wdt_always_on;
      next_st.reset_vector = i_boot_reloc ? BOOT_START :
                             sleep_reset_watchdog_control_pkg::RESET_VECTOR_DEFAULT;
    end
  end

  always_ff @(posedge i_mclk) begin
    st <= next_st;
  end

  assign o_hreadyout    = 1'b1;
  assign o_hresp        = 1'b0;
  assign o_hrdata       = st.hrdata;
  assign o_clk_en       = clk_now;
  // Gating freezes the peripheral rather than resetting it, so its state is kept.
  assign o_per_clk_en   = {sleep_reset_watchdog_control_pkg::PR_WIDTH{clk_now.per}} &
                          ~st.power_red;
  assign o_sleeping     = st.pstate == sleep_reset_watchdog_control_pkg::PS_SLEEP;
  assign o_reset_vector = st.reset_vector;

endmodule // sleep_reset_watchdog_control

/* src/sleep_reset_watchdog_control_pkg.sv */
// Constants, register map and carrier types for the sleep, reset and watchdog controller.
// Assumes a single 200 MHz clock and an AHB-Lite master issuing single word transfers.
package sleep_reset_watchdog_control_pkg;

  localparam logic [7:0] OFS_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] OFS_POWER_RED  = 8'h04;
  localparam logic [7:0] OFS_RST_CAUSE  = 8'h08;
  localparam logic [7:0] OFS_PROT_KEY   = 8'h0c;
  localparam logic [7:0] OFS_SW_RST     = 8'h10;
  localparam logic [7:0] OFS_WDT_CTRL   = 8'h14;
  localparam logic [7:0] OFS_WDT_WIN    = 8'h18;
  localparam logic [7:0] OFS_STATUS     = 8'h1c;

  // The unlock key value is arbitrary.
  localparam logic [7:0] PROT_KEY_VALUE  = 8'h5a;
  localparam logic [2:0] PROT_WINDOW_CYC = 3'h4;

  localparam int          SLEEP_EN_BIT  = 0;
  localparam int          SLEEP_MODE_LO = 1;
  localparam logic [2:0]  MODE_IDLE     = 3'h0;
  localparam logic [2:0]  MODE_PDOWN    = 3'h2;
  localparam logic [2:0]  MODE_PSAVE    = 3'h3;
  localparam logic [2:0]  MODE_STDBY    = 3'h6;
  localparam logic [2:0]  MODE_ESTDBY   = 3'h7;

  localparam int PR_WIDTH     = 16;
  localparam int WDT_EN_BIT   = 0;
  localparam int WDT_WIN_BIT  = 1;
  localparam int WDT_PER_LO   = 4;
  localparam int SW_RST_BIT   = 0;

  localparam int          CAUSE_WIDTH  = 7;
  localparam int          CAUSE_POR    = 0;
  localparam int          CAUSE_EXT    = 1;
  localparam int          CAUSE_BOD    = 2;
  localparam int          CAUSE_WDT    = 3;
  localparam int          CAUSE_JTAG   = 4;
  localparam int          CAUSE_DEBUG  = 5;
  localparam int          CAUSE_SW     = 6;

  localparam int          WDT_TICK_MS    = 1;
  localparam int          WDT_MIN_MS     = 8;
  localparam logic [3:0]  WDT_PER_MAX    = 4'ha;
  localparam int          WDT_CNT_WIDTH  = 14;
  localparam logic [13:0] WDT_BASE_TICKS = 14'(WDT_MIN_MS / WDT_TICK_MS);

  localparam int          RST_SYNC_STAGES = 2;
  localparam logic [15:0] RESET_VECTOR_DEFAULT = 16'h0000;

  typedef enum logic {PS_ACTIVE, PS_SLEEP} power_state_e;

  typedef struct packed {
    logic cpu;
    logic nvm;
    logic per;
    logic rtc;
    logic sys_src;
  } clk_en_s;

  typedef struct packed {
    logic [CAUSE_WIDTH-1:0] cause;
    power_state_e           pstate;
    logic                   sleep_en;
    logic [2:0]             sleep_mode;
    logic [PR_WIDTH-1:0]    power_red;
    logic [2:0]             unlock_cnt;
    logic                   wdt_en;
    logic                   wdt_win;
    logic [3:0]             wdt_per;
    logic [3:0]             wdt_wper;
    logic [13:0]            wdt_cnt;
    logic                   wdt_fire;
    logic                   sw_fire;
    logic                   dp_write;
    logic [7:0]             dp_addr;
    logic [31:0]            hrdata;
    logic [15:0]            reset_vector;
  } ctrl_state_s;

endpackage

/* tb/sleep_reset_watchdog_control_monitor.sv */
// Checker for the sleep, reset and watchdog controller, bound to its top module.
// Assumes the single clock i_mclk and the synchronous block reset i_sys_rst.
`timescale 1ns/1ps
module sleep_reset_watchdog_control_monitor #(
  parameter logic [15:0] BOOT_START = 16'h8000
) (
  input wire logic i_mclk, i_sys_rst, i_por_low, i_ext_rst_n, i_bod_low, i_bod_enable,
  input wire logic i_jtag_rst_bit, i_program_debug_link_rst, i_boot_reloc, i_sleep_exec,
  input wire logic i_irq_twi_match, i_irq_port_async, o_sleeping, o_sys_reset, o_io_tristate,
  input wire logic [15:0] o_reset_vector, o_per_clk_en,
  input sleep_reset_watchdog_control_pkg::clk_en_s o_clk_en
);
  logic pin_src;
  assign pin_src = i_por_low | !i_ext_rst_n | (i_bod_low & i_bod_enable) | i_jtag_rst_bit
                 | i_program_debug_link_rst;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  property p_ext_hold; !i_ext_rst_n |-> o_sys_reset; endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("pin low without reset");
  property p_supply_hold; i_por_low || (i_bod_low && i_bod_enable) |-> o_sys_reset; endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("low supply no reset");
  property p_scan_hold; i_jtag_rst_bit |-> o_sys_reset; endproperty
  a_scan_hold: assert property (p_scan_hold) else $error("scan bit without reset");
  property p_pins_hiz; pin_src |-> o_io_tristate && o_sys_reset; endproperty
  a_pins_hiz: assert property (p_pins_hiz) else $error("pins not released");
  property p_clean_release; $fell(o_sys_reset) |-> !pin_src && !$past(pin_src); endproperty
  a_clean_release: assert property (p_clean_release) else $error("early release");
  property p_vector;
    $fell(o_sys_reset) |-> o_reset_vector == ($past(i_boot_reloc) ? BOOT_START : 16'h0000);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong reset vector");
  property p_reset_clears; o_sys_reset ##1 o_sys_reset |-> !o_sleeping && &o_per_clk_en; endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("state kept in reset");
  property p_sleep_entry; $rose(o_sleeping) |-> $past(i_sleep_exec); endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without command");
  property p_cpu_off; o_sleeping |-> !o_clk_en.cpu && !o_clk_en.nvm; endproperty
  a_cpu_off: assert property (p_cpu_off) else $error("cpu clock in sleep");
  property p_async_wake;
    o_sleeping && !o_clk_en.per && (i_irq_twi_match || i_irq_port_async) |=> !o_sleeping;
  endproperty
  a_async_wake: assert property (p_async_wake) else $error("no async wake");
endmodule // sleep_reset_watchdog_control_monitor
bind sleep_reset_watchdog_control sleep_reset_watchdog_control_monitor #(
  .BOOT_START(BOOT_START)) u_mon (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_por_low(i_por_low), .i_ext_rst_n(i_ext_rst_n), .i_bod_low(i_bod_low),
  .i_bod_enable(i_bod_enable), .i_jtag_rst_bit(i_jtag_rst_bit),
  .i_program_debug_link_rst(i_program_debug_link_rst), .i_boot_reloc(i_boot_reloc),
  .i_sleep_exec(i_sleep_exec), .i_irq_twi_match(i_irq_twi_match),
  .i_irq_port_async(i_irq_port_async), .o_sleeping(o_sleeping), .o_sys_reset(o_sys_reset),
  .o_io_tristate(o_io_tristate), .o_reset_vector(o_reset_vector),
  .o_per_clk_en(o_per_clk_en), .o_clk_en(o_clk_en));

/* tb/srwc_far_side.sv */
// Far side model: slow oscillator tick and the core's watchdog restart instruction.
// Assumes i_kick is a one-cycle request from the bench.
`timescale 1ns/1ps
module srwc_far_side #(
  parameter int TICK_CYC = 10
) (
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  input  wire logic i_kick,
  output logic      o_tick,
  output logic      o_restart
);
  int div;
  // The tick is shortened to a few system clocks so watchdog periods stay short in time.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      div       <= 0;
      o_tick    <= 1'b0;
      o_restart <= 1'b0;
    end else begin
      div       <= (div == TICK_CYC - 1) ? 0 : div + 1;
      o_tick    <= (div == TICK_CYC - 1);
      o_restart <= i_kick;
    end
  end
endmodule // srwc_far_side

/* tb/tb.sv */
// Testbench for the sleep, reset and watchdog controller over its AHB-Lite registers.
// Assumes a zero-wait single slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module tb;
  localparam int TICK_CYC = 10;
  logic        i_mclk, i_sys_rst, hsel, hwrite, kick, sleep_exec, reloc, rtc_en, bod_en, aon;
  logic        hreadyout, hresp, sleeping, sys_reset, tristate, tick, restart;
  logic [1:0]  htrans;
  logic [4:0]  src;
  logic [3:0]  irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] per_en, rvec;
  sleep_reset_watchdog_control_pkg::clk_en_s clk_en;
  int          n_errors, comparisons, cyc;
  int          cbit [5] = '{0, 1, 2, 4, 5};
  logic [2:0]  mode [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [4:0]  ce   [5] = '{5'h07, 5'h00, 5'h02, 5'h01, 5'h03};
  logic [3:0]  bad  [5] = '{4'h0, 4'h1, 4'h8, 4'h1, 4'h8};
  logic [3:0]  good [5] = '{4'h8, 4'h2, 4'h1, 4'h4, 4'h1};
  sleep_reset_watchdog_control u_sleep_reset_watchdog_control (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata), .i_por_low(src[0]),
    .i_ext_rst_n(!src[1]), .i_bod_low(src[2]), .i_bod_enable(bod_en),
    .i_jtag_rst_bit(src[3]), .i_program_debug_link_rst(src[4]), .i_boot_reloc(reloc),
    .i_wdt_always_on(aon), .i_wdt_tick(tick), .i_watchdog_restart_instruction(restart),
    .i_sleep_exec(sleep_exec), .i_irq_enabled_any(irq[3]), .i_irq_twi_match(irq[2]),
    .i_irq_port_async(irq[1]), .i_irq_rtc(irq[0]), .i_rtc_enabled(rtc_en), .o_clk_en(clk_en),
    .o_per_clk_en(per_en), .o_sleeping(sleeping), .o_sys_reset(sys_reset),
    .o_io_tristate(tristate), .o_reset_vector(rvec));
  srwc_far_side #(.TICK_CYC(TICK_CYC)) u_srwc_far_side (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_kick(kick), .o_tick(tick), .o_restart(restart));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge i_mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge i_mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic pwr(input logic [7:0] a, input logic [31:0] d);
    wr(sleep_reset_watchdog_control_pkg::OFS_PROT_KEY, 32'h5a);
    wr(a, d);
  endtask
  task automatic settle();
    int t;
    t = 0;
    do begin @(posedge i_mclk); t++; end while (sys_reset !== 1'b0 && t < 400);
  endtask
  task automatic wait_hi(input int lim);
    int t;
    t = 0;
    while (sys_reset !== 1'b1 && t < lim) begin @(posedge i_mclk); t++; end
    chk("reset raised", {31'h0, sys_reset}, 32'h1);
    settle();
    rdchk("cause", sleep_reset_watchdog_control_pkg::OFS_RST_CAUSE, 32'h1 << lim % 7);
    wr(sleep_reset_watchdog_control_pkg::OFS_RST_CAUSE, 32'h7f);
  endtask
  initial begin
    i_sys_rst = 1'b1; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
    kick = 1'b0; sleep_exec = 1'b0; reloc = 1'b0; rtc_en = 1'b1; bod_en = 1'b1; src = 5'h0;
    irq = 4'h0; aon = 1'b0; n_errors = 0; comparisons = 0; cyc = 0;
    repeat (10) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    settle();
    rdchk("cause clear", sleep_reset_watchdog_control_pkg::OFS_RST_CAUSE, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
    for (int k = 0; k < 5; k++) begin
      reloc <= k[0]; src <= 5'h1 << k;
      repeat (3) @(posedge i_mclk);
      chk("pins hiz", {31'h0, tristate}, 32'h1);
      src <= 5'h0;
      settle();
      chk("vector", {16'h0, rvec}, k[0] ? 32'h8000 : 32'h0);
      rdchk("cause", sleep_reset_watchdog_control_pkg::OFS_RST_CAUSE, 32'h1 << cbit[k]);
      wr(sleep_reset_watchdog_control_pkg::OFS_RST_CAUSE, 32'h7f);
    end
    bod_en <= 1'b0; src <= 5'h4;
    repeat (3) @(posedge i_mclk);
    chk("brown-out off", {31'h0, sys_reset}, 32'h0);
    src <= 5'h0; bod_en <= 1'b1;
    wr(sleep_reset_watchdog_control_pkg::OFS_PROT_KEY, 32'h5a);
    rdchk("unlocked", sleep_reset_watchdog_control_pkg::OFS_STATUS, 32'h2);
    // The unlock has lapsed by the time this write's data phase arrives.
    repeat (2) @(posedge i_mclk);
    wr(sleep_reset_watchdog_control_pkg::OFS_WDT_CTRL, 32'h1);
    rdchk("locked ctrl", sleep_reset_watchdog_control_pkg::OFS_WDT_CTRL, 32'h0);
    wr(sleep_reset_watchdog_control_pkg::OFS_POWER_RED, 32'ha5);
    @(posedge i_mclk);
    chk("gated clocks", {16'h0, per_en}, 32'hff5a);
    for (int m = 0; m < 5; m++) begin
      wr(sleep_reset_watchdog_control_pkg::OFS_SLEEP_CTRL, {28'h0, mode[m], 1'b1});
      sleep_exec <= 1'b1;
      @(posedge i_mclk);
      sleep_exec <= 1'b0;
      @(posedge i_mclk);
      chk("asleep", {31'h0, sleeping}, 32'h1);
      chk("sleep clocks", {27'h0, clk_en}, {27'h0, ce[m]});
      irq <= bad[m];
      repeat (2) @(posedge i_mclk);
      chk("not woken", {31'h0, sleeping}, 32'h1);
      irq <= good[m];
      repeat (2) @(posedge i_mclk);
      chk("woken", {31'h0, sleeping}, 32'h0);
      irq <= 4'h0;
    end
    // Period code 0 expires after eight ticks, so no reset may come within five.
    pwr(sleep_reset_watchdog_control_pkg::OFS_WDT_CTRL, 32'h1);
    repeat (5 * TICK_CYC) @(posedge i_mclk);
    chk("no early expiry", {31'h0, sys_reset}, 32'h0);
    wait_hi(3 + 7 * 10);
    pwr(sleep_reset_watchdog_control_pkg::OFS_WDT_WIN, 32'h0);
    pwr(sleep_reset_watchdog_control_pkg::OFS_WDT_CTRL, 32'h13);
    kick <= 1'b1;
    @(posedge i_mclk);
    kick <= 1'b0;
    wait_hi(3 + 7 * 2);
    aon <= 1'b1;
    pwr(sleep_reset_watchdog_control_pkg::OFS_WDT_CTRL, 32'h0);
    rdchk("always on", sleep_reset_watchdog_control_pkg::OFS_WDT_CTRL, 32'h1);
    aon <= 1'b0;
    pwr(sleep_reset_watchdog_control_pkg::OFS_WDT_CTRL, 32'h0);
    pwr(sleep_reset_watchdog_control_pkg::OFS_SW_RST, 32'h1);
    wait_hi(6 + 7 * 3);
    complete_run();
  end
endmodule // tb
